// *** rtl/mrs_modbus_slave.sv ***
/*
 * MODBUS-RTU slave engine: UART receive and transmit on an RS-485
 * transceiver, frame delimiting, CRC check, function decode and a
 * 32-word register store, plus an APB slave for configuration.
 * Assumes RXD_I is asynchronous to CLOCK_I and that an external
 * transceiver drives the bus while DE_O is high.
 */
`timescale 1ns/1ps
`default_nettype none

module mrs_modbus_slave
   import mrs_pkg::*;
#(
   parameter int unsigned CLK_HZ_P = CLK_HZ
) (
   // clock and reset
   input wire logic CLOCK_I,
   input wire logic RESET_N_I,
   // apb slave
   input wire logic PSEL_I,
   input wire logic PENABLE_I,
   input wire logic PWRITE_I,
   input wire logic [11:0] PADDR_I,
   input wire logic [31:0] PWDATA_I,
   output logic [31:0] PRDATA_O,
   output logic PREADY_O,
   output logic PSLVERR_O,
   // rs-485 transceiver
   input wire logic RXD_I,
   output logic TXD_O,
   output logic DE_O
);

   ////////////////////////////////////////////////////////////////////////////
   typedef struct packed {
      logic rx_s1;
      logic rx_s2;
      logic [31:0] ctrl;
      logic [31:0] prot;
      logic [NWORDS-1:0][15:0] mem;
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
      logic rx_busy;
      logic [19:0] rx_cnt;
      logic [3:0] rx_bit;
      logic [10:0] rx_sh;
      logic [20:0] gap_cnt;
      logic [47:0][7:0] buff;
      logic [5:0] len;
      logic bad;
      logic [15:0] crc;
      mrs_state_type st;
      logic bcast;
      logic [4:0] base;
      logic [4:0] num;
      logic [4:0] idx;
      logic [5:0] tx_len;
      logic [5:0] tx_pos;
      logic tx_busy;
      logic [19:0] tx_cnt;
      logic [3:0] tx_bit;
      logic [11:0] tx_sh;
      logic txd;
      logic de;
      logic [7:0] cnt_ok;
      logic [7:0] cnt_err;
   } mrs_regs_type;

   mrs_regs_type q;
   mrs_regs_type d;

   function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] b);
      logic [15:0] r;
      r = c ^ {8'h00, b};
      for (int k = 0; k < 8; k++) begin
         r = r[0] ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
      end
      return r;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // character format derived from the control register
   logic [7:0] station;
   logic [2:0] baud_sel;
   logic [1:0] par_sel;
   logic par_en;
   logic par_odd;
   logic stop2;
   logic running;
   logic [3:0] nb;
   logic [3:0] rx_last;
   logic [19:0] div;
   logic [31:0] gap_full;
   logic [20:0] gap_lim;

   always_comb begin
      station = q.ctrl[CTRL_ADDR_LSB +: 8];
      baud_sel = q.ctrl[CTRL_BAUD_LSB +: 3];
      par_sel = q.ctrl[CTRL_PAR_LSB +: 2];
      par_en = (par_sel == PAR_EVEN) || (par_sel == PAR_ODD);
      par_odd = (par_sel == PAR_ODD);
      stop2 = q.ctrl[CTRL_STOP2_BIT];
      running = q.ctrl[CTRL_RUN_BIT];
      nb = 4'hA + {3'h0, par_en} + {3'h0, stop2};
      rx_last = 4'h9 + {3'h0, par_en};
      unique case (baud_sel)
         3'h0: div = 20'(CLK_HZ_P / BAUD_0);
         3'h2: div = 20'(CLK_HZ_P / BAUD_2);
         3'h3: div = 20'(CLK_HZ_P / BAUD_3);
         3'h4: div = 20'(CLK_HZ_P / BAUD_4);
         3'h5: div = 20'(CLK_HZ_P / BAUD_5);
         default: div = 20'(CLK_HZ_P / BAUD_1);
      endcase
      gap_full = (32'(GAP_NUM) * {28'h0, nb} * {12'h0, div}) / 32'(GAP_DEN);
      gap_lim = gap_full[20:0];
   end

   ////////////////////////////////////////////////////////////////////////////
   // apb read decode
   logic apb_hit;
   logic mem_hit;
   logic [31:0] apb_rd;
   logic [31:0] stat;

   always_comb begin
      stat = {15'h0, q.st != ST_RX, q.cnt_err, q.cnt_ok};
      mem_hit = (PADDR_I[11:7] == OFS_MEM[11:7]) && (PADDR_I[1:0] == 2'h0);
      apb_hit = 1'b1;
      apb_rd = 32'h0000_0000;
      if (PADDR_I == OFS_CTRL) begin
         apb_rd = q.ctrl;
      end else if (PADDR_I == OFS_STAT) begin
         apb_rd = stat;
      end else if (PADDR_I == OFS_PROT) begin
         apb_rd = q.prot;
      end else if (mem_hit) begin
         apb_rd = {16'h0000, q.mem[PADDR_I[6:2]]};
      end else begin
         apb_hit = 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // next state
   logic [7:0] rx_byte;
   logic [7:0] fc;
   logic [15:0] a16;
   logic [15:0] n16;
   logic [16:0] a_end;
   logic [31:0] pmask;
   logic own;
   logic n_ok;
   logic [7:0] exc;
   logic go;
   logic respond;
   logic rearm;
   logic [4:0] ia;
   logic [5:0] di;
   logic [5:0] ri;
   logic [7:0] tx_byte;
   logic [11:0] sh;

   always_comb begin
      d = q;
      rx_byte = q.rx_sh[8:1];
      fc = q.buff[1];
      a16 = {q.buff[2], q.buff[3]};
      n16 = {q.buff[4], q.buff[5]};
      a_end = {1'b0, a16} + {1'b0, n16};
      pmask = (q.prot >> a16[4:0]) & ((32'h0000_0001 << n16[4:0]) - 32'h0000_0001);
      own = (station >= ADDR_MIN) && (station <= ADDR_MAX) && (q.buff[0] == station);
      n_ok = (n16 != 16'h0000) && (n16 <= MAX_REGS);
      exc = 8'h00;
      go = 1'b0;
      respond = 1'b0;
      rearm = 1'b0;
      ia = q.base + q.idx;
      di = ((fc == FC_WR1) || (fc == FC_VWR1)) ? 6'h04 : ({q.idx, 1'b0} + 6'h07);
      ri = {q.idx, 1'b0} + 6'h03;
      tx_byte = 8'h00;
      sh = 12'hFFF;
      d.rx_s1 = RXD_I;
      d.rx_s2 = q.rx_s1;

      // apb: one wait state, write lands on the completing edge
      d.pready = 1'b0;
      d.pslverr = 1'b0;
      if (PSEL_I && PENABLE_I && !q.pready) begin
         d.pready = 1'b1;
         d.pslverr = !apb_hit;
         d.prdata = apb_rd;
      end
      if (PSEL_I && PENABLE_I && q.pready && PWRITE_I) begin
         if (PADDR_I == OFS_CTRL) begin
            d.ctrl = PWDATA_I;
         end
         if (PADDR_I == OFS_PROT) begin
            d.prot = PWDATA_I;
         end
         if (mem_hit) begin
            d.mem[PADDR_I[6:2]] = PWDATA_I[15:0];
         end
      end

      unique case (q.st)
         // receiver; half duplex, so it only listens in this state
         ST_RX: begin
            if (!q.rx_busy) begin
               if (!q.rx_s2) begin
                  d.rx_busy = 1'b1;
                  d.rx_cnt = div >> 1;
                  d.rx_bit = 4'h0;
                  d.gap_cnt = 21'h0;
               end else if (q.gap_cnt < gap_lim) begin
                  d.gap_cnt = q.gap_cnt + 21'h1;
               end else if (q.len != 6'h00) begin
                  d.st = ST_CHECK;
               end
            end else if (q.rx_cnt != 20'h0) begin
               d.rx_cnt = q.rx_cnt - 20'h1;
            end else begin
               d.rx_sh[q.rx_bit] = q.rx_s2;
               d.rx_cnt = div - 20'h1;
               d.rx_bit = q.rx_bit + 4'h1;
               if ((q.rx_bit == 4'h0) && q.rx_s2) begin
                  d.rx_busy = 1'b0;
               end else if (q.rx_bit == rx_last) begin
                  d.rx_busy = 1'b0;
                  if (!q.rx_s2 || (par_en && (q.rx_sh[9] != ((^rx_byte) ^ par_odd)))) begin
                     d.bad = 1'b1;
                  end
                  if (q.len < BUF_LEN) begin
                     d.buff[q.len] = rx_byte;
                     d.len = q.len + 6'h01;
                  end else begin
                     d.bad = 1'b1;
                  end
                  d.crc = crc_byte(q.crc, rx_byte);
               end
            end
         end

         // decode a complete frame in one cycle
         ST_CHECK: begin
            d.bcast = (q.buff[0] == BCAST_ADDR);
            d.base = a16[4:0];
            d.num = n16[4:0];
            d.idx = 5'h00;
            if (q.bad || (q.len < 6'h04) || (q.crc != 16'h0000)) begin
               d.cnt_err = q.cnt_err + 8'h01;
               rearm = 1'b1;
            end else if (!own && !d.bcast) begin
               rearm = 1'b1;
            end else begin
               unique case (fc)
                  FC_READ: begin
                     if ((q.len != 6'h08) || !n_ok) begin
                        exc = EXC_VAL;
                     end else if (a_end > 17'(NWORDS)) begin
                        exc = EXC_ADDR;
                     end else begin
                        go = 1'b1;
                     end
                  end
                  FC_WR1, FC_VWR1: begin
                     d.num = 5'h01;
                     if (q.len != 6'h08) begin
                        exc = EXC_VAL;
                     end else if (a16 >= 16'(NWORDS)) begin
                        exc = EXC_ADDR;
                     end else if ((fc == FC_VWR1) && running && q.prot[a16[4:0]]) begin
                        exc = EXC_FUNC;
                     end else begin
                        go = 1'b1;
                     end
                  end
                  FC_WRN, FC_VWRN: begin
                     if (!n_ok || (q.buff[6] != {n16[6:0], 1'b0})
                         || (q.len != ({n16[4:0], 1'b0} + 6'h09))) begin
                        exc = EXC_VAL;
                     end else if (a_end > 17'(NWORDS)) begin
                        exc = EXC_ADDR;
                     end else if ((fc == FC_VWRN) && running && (pmask != 32'h0)) begin
                        exc = EXC_FUNC;
                     end else begin
                        go = 1'b1;
                     end
                  end
                  FC_DIAG: begin
                     if (q.len != 6'h08) begin
                        exc = EXC_VAL;
                     end else if (a16 != 16'h0000) begin
                        exc = EXC_FUNC;
                     end else begin
                        d.tx_len = 6'h06;
                        respond = 1'b1;
                     end
                  end
                  default: begin
                     exc = EXC_FUNC;
                  end
               endcase
               if (exc != 8'h00) begin
                  d.buff[1] = fc | FC_EXC;
                  d.buff[2] = exc;
                  d.tx_len = 6'h03;
                  respond = 1'b1;
               end else if (go) begin
                  d.st = ST_RUN;
               end
            end
         end

         // one word per cycle; reply only after every word is done
         ST_RUN: begin
            if (fc == FC_READ) begin
               d.buff[ri] = q.mem[ia][15:8];
               d.buff[ri + 6'h01] = q.mem[ia][7:0];
            end else begin
               d.mem[ia] = {q.buff[di], q.buff[di + 6'h01]};
            end
            if (q.idx == (q.num - 5'h01)) begin
               if (fc == FC_READ) begin
                  d.buff[2] = {2'h0, q.num, 1'b0};
                  d.tx_len = {q.num, 1'b0} + 6'h03;
               end else begin
                  d.tx_len = 6'h06;
               end
               respond = 1'b1;
            end else begin
               d.idx = q.idx + 5'h01;
            end
         end

         // transmitter: buffer bytes, then crc low, then crc high
         ST_TX: begin
            if (!q.tx_busy) begin
               if (q.tx_pos == (q.tx_len + 6'h02)) begin
                  d.de = 1'b0;
                  d.cnt_ok = q.cnt_ok + 8'h01;
                  rearm = 1'b1;
               end else begin
                  if (q.tx_pos < q.tx_len) begin
                     tx_byte = q.buff[q.tx_pos];
                     d.crc = crc_byte(q.crc, tx_byte);
                  end else if (q.tx_pos == q.tx_len) begin
                     tx_byte = q.crc[7:0];
                  end else begin
                     tx_byte = q.crc[15:8];
                  end
                  sh[0] = 1'b0;
                  sh[8:1] = tx_byte;
                  if (par_en) begin
                     sh[9] = (^tx_byte) ^ par_odd;
                  end
                  d.tx_sh = sh;
                  d.txd = 1'b0;
                  d.tx_busy = 1'b1;
                  d.tx_bit = 4'h0;
                  d.tx_cnt = div - 20'h1;
                  d.tx_pos = q.tx_pos + 6'h01;
               end
            end else if (q.tx_cnt != 20'h0) begin
               d.tx_cnt = q.tx_cnt - 20'h1;
            end else if (q.tx_bit == (nb - 4'h1)) begin
               d.tx_busy = 1'b0;
            end else begin
               d.tx_bit = q.tx_bit + 4'h1;
               d.tx_sh = {1'b1, q.tx_sh[11:1]};
               d.txd = q.tx_sh[1];
               d.tx_cnt = div - 20'h1;
            end
         end
      endcase

      // d.bcast is this frame's flag in ST_CHECK and ST_RUN, the states that set respond; q.bcast may be the last frame's
      if (respond) begin
         if (d.bcast) begin
            rearm = 1'b1;
         end else begin
            d.st = ST_TX;
            d.tx_pos = 6'h00;
            d.tx_busy = 1'b0;
            d.crc = CRC_INIT;
            d.de = 1'b1;
         end
      end
      if (rearm) begin
         d.st = ST_RX;
         d.len = 6'h00;
         d.bad = 1'b0;
         d.crc = CRC_INIT;
         d.gap_cnt = 21'h0;
         d.rx_busy = 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   always_ff @(posedge CLOCK_I) begin
      if (!RESET_N_I) begin
         q <= '0;
         q.rx_s1 <= 1'b1;
         q.rx_s2 <= 1'b1;
         q.ctrl <= CTRL_RESET;
         q.prot <= PROT_RESET;
         q.crc <= CRC_INIT;
         q.st <= ST_RX;
         q.tx_sh <= 12'hFFF;
         q.txd <= 1'b1;
      end else begin
         q <= d;
      end
   end

   assign PRDATA_O = q.prdata;
   assign PREADY_O = q.pready;
   assign PSLVERR_O = q.pslverr;
   assign TXD_O = q.txd;
   assign DE_O = q.de;

endmodule // mrs_modbus_slave

`default_nettype wire

// *** rtl/mrs_pkg.sv ***
/*
 * Constants for the MODBUS-RTU slave engine: register map, field layout,
 * reset values, protocol codes and the engine state encoding.
 * Assumes a 100 MHz system clock and an APB master with 12-bit addresses.
 */
`default_nettype none

package mrs_pkg;

   localparam int unsigned CLK_HZ = 100_000_000;

   // apb register offsets (byte addresses)
   localparam logic [11:0] OFS_CTRL = 12'h000;
   localparam logic [11:0] OFS_STAT = 12'h004;
   localparam logic [11:0] OFS_PROT = 12'h008;
   localparam logic [11:0] OFS_MEM = 12'h100;

   // control register fields
   localparam int CTRL_ADDR_LSB = 0;
   localparam int CTRL_BAUD_LSB = 8;
   localparam int CTRL_PAR_LSB = 11;
   localparam int CTRL_STOP2_BIT = 13;
   localparam int CTRL_RUN_BIT = 14;
   localparam logic [31:0] CTRL_RESET = 32'h0000_0101;
   localparam logic [31:0] PROT_RESET = 32'h0000_0000;

   // parity selections
   localparam logic [1:0] PAR_EVEN = 2'h1;
   localparam logic [1:0] PAR_ODD = 2'h2;

   // bit rates, selected by the baud field 0..5
   localparam int unsigned BAUD_0 = 4800;
   localparam int unsigned BAUD_1 = 9600;
   localparam int unsigned BAUD_2 = 19200;
   localparam int unsigned BAUD_3 = 38400;
   localparam int unsigned BAUD_4 = 57600;
   localparam int unsigned BAUD_5 = 115200;

   // word store and frame buffer
   localparam int NWORDS = 32;
   localparam logic [5:0] BUF_LEN = 6'h30;
   localparam logic [15:0] MAX_REGS = 16'h0010;

   // station addressing
   localparam logic [7:0] BCAST_ADDR = 8'h00;
   localparam logic [7:0] ADDR_MIN = 8'h01;
   localparam logic [7:0] ADDR_MAX = 8'hF7;

   // function and exception codes
   localparam logic [7:0] FC_READ = 8'h03;
   localparam logic [7:0] FC_WR1 = 8'h06;
   localparam logic [7:0] FC_DIAG = 8'h08;
   localparam logic [7:0] FC_WRN = 8'h10;
   localparam logic [7:0] FC_VWR1 = 8'h41;
   localparam logic [7:0] FC_VWRN = 8'h42;
   localparam logic [7:0] FC_EXC = 8'h80;
   localparam logic [7:0] EXC_FUNC = 8'h01;
   localparam logic [7:0] EXC_ADDR = 8'h02;
   localparam logic [7:0] EXC_VAL = 8'h03;

   // crc-16, reflected polynomial
   localparam logic [15:0] CRC_INIT = 16'hFFFF;
   localparam logic [15:0] CRC_POLY = 16'hA001;

   // inter-frame gap of 3.5 characters, as a fraction
   localparam int GAP_NUM = 7;
   localparam int GAP_DEN = 2;

   typedef enum logic [3:0] {
      ST_RX = 4'b0001,
      ST_CHECK = 4'b0010,
      ST_RUN = 4'b0100,
      ST_TX = 4'b1000
   } mrs_state_type;

endpackage

`default_nettype wire

// *** dv/mrs_modbus_slave_checker.sv ***
/*
 * Port-level assertions for the modbus slave engine: apb handshake timing
 * and the shape of the serial answer on TXD_O and DE_O.
 * Assumes a bit lasts at least 4 clock cycles at the configured rate.
 */
`timescale 1ns/1ps
`default_nettype none

module mrs_modbus_slave_checker
   import mrs_pkg::*;
#(
   parameter int unsigned CLK_HZ_P = CLK_HZ
) (
   // clock and reset
   input wire logic CLOCK_I,
   input wire logic RESET_N_I,
   // apb
   input wire logic PSEL_I,
   input wire logic PENABLE_I,
   input wire logic PWRITE_I,
   input wire logic [11:0] PADDR_I,
   input wire logic [31:0] PWDATA_I,
   input wire logic [31:0] PRDATA_O,
   input wire logic PREADY_O,
   input wire logic PSLVERR_O,
   // serial line
   input wire logic RXD_I,
   input wire logic TXD_O,
   input wire logic DE_O
);
   default clocking cb @(posedge CLOCK_I);
   endclocking
   default disable iff (!RESET_N_I);

   ////////////////////////////////////////
   property p_ready_wait;
      PSEL_I && PENABLE_I && !PREADY_O |=> PREADY_O;
   endproperty
   a_ready_wait: assert property (p_ready_wait) else $error("ready late");
   property p_ready_pulse;
      PREADY_O |=> !PREADY_O;
   endproperty
   a_ready_pulse: assert property (p_ready_pulse) else $error("ready held");
   property p_ready_cause;
      PREADY_O |-> $past(PSEL_I) && $past(PENABLE_I);
   endproperty
   a_ready_cause: assert property (p_ready_cause) else $error("ready uncaused");
   property p_setup_idle;
      PSEL_I && !PENABLE_I |=> !PREADY_O;
   endproperty
   a_setup_idle: assert property (p_setup_idle) else $error("ready early");
   property p_err_data;
      PSLVERR_O |-> PREADY_O && PRDATA_O == 32'h0000_0000;
   endproperty
   a_err_data: assert property (p_err_data) else $error("bad error cycle");
   property p_idle_high;
      !DE_O |-> TXD_O;
   endproperty
   a_idle_high: assert property (p_idle_high) else $error("line not idle");
   property p_start;
      $rose(DE_O) |-> ##[0:1] !TXD_O;
   endproperty
   a_start: assert property (p_start) else $error("no start bit");
   property p_bit_len;
      $fell(TXD_O) |-> !TXD_O [*4];
   endproperty
   a_bit_len: assert property (p_bit_len) else $error("bit too short");
   property p_de_hold;
      $rose(DE_O) |-> DE_O [*8];
   endproperty
   a_de_hold: assert property (p_de_hold) else $error("driver dropped");
   c_answer: cover property ($rose(DE_O));
   c_err: cover property (PSLVERR_O);
   c_write: cover property (PREADY_O && PWRITE_I);
endmodule // mrs_modbus_slave_checker

bind mrs_modbus_slave mrs_modbus_slave_checker #(.CLK_HZ_P(CLK_HZ_P)) chk_i (
   .CLOCK_I(CLOCK_I), .RESET_N_I(RESET_N_I), .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I),
   .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I), .PWDATA_I(PWDATA_I), .PRDATA_O(PRDATA_O),
   .PREADY_O(PREADY_O), .PSLVERR_O(PSLVERR_O), .RXD_I(RXD_I), .TXD_O(TXD_O), .DE_O(DE_O));

`default_nettype wire

// *** dv/mrs_master_model.sv ***
/*
 * Bus master model: sends request frames with crc and collects the answer.
 * Assumes the bench sets div_v, par_v and stop2_v to match CTRL.
 */
`timescale 1ns/1ps
`default_nettype none

module mrs_master_model
   import mrs_pkg::*;
(
   // clock
   input wire logic clk_i,
   // slave transmit side
   input wire logic txd_i,
   input wire logic de_i,
   // slave receive side
   output logic rxd_o
);
   int div_v = 10;
   logic [1:0] par_v = 2'h0;
   logic stop2_v = 1'b0;
   logic bad_v = 1'b0;
   logic [7:0] tx_b [0:19];
   logic [7:0] rx_b [0:39];
   int rx_n = 0;
   logic fmt_ok = 1'b1;
   initial rxd_o = 1'b1;

   ////////////////////////////////////////
   function automatic logic [15:0] crc_of(input logic rx, input int n);
      logic [15:0] c;
      c = CRC_INIT;
      for (int i = 0; i < n; i++) begin
         c = c ^ {8'h00, rx ? rx_b[i] : tx_b[i]};
         for (int k = 0; k < 8; k++) c = c[0] ? (c >> 1) ^ CRC_POLY : c >> 1;
      end
      return c;
   endfunction
   function automatic logic par_of(input logic [7:0] b);
      return ^b ^ (par_v == PAR_ODD);
   endfunction
   task automatic put_bit(input logic v);
      rxd_o <= v;
      repeat (div_v) @(posedge clk_i);
   endtask
   // bad_v flips one crc bit so the frame must be dropped
   task automatic send(input int n);
      logic [15:0] c;
      c = crc_of(1'b0, n) ^ {15'h0000, bad_v};
      tx_b[n] = c[7:0];
      tx_b[n + 1] = c[15:8];
      @(posedge clk_i);
      for (int i = 0; i < n + 2; i++) begin
         put_bit(1'b0);
         for (int k = 0; k < 8; k++) put_bit(tx_b[i][k]);
         if (par_v inside {PAR_EVEN, PAR_ODD}) put_bit(par_of(tx_b[i]));
         repeat (stop2_v ? 2 : 1) put_bit(1'b1);
      end
   endtask
   // ends after a long idle, so the next request keeps the frame gap
   task automatic recv();
      int t;
      logic [7:0] b;
      rx_n = 0;
      fmt_ok = 1'b1;
      t = 80 * div_v;
      while (t > 0) begin
         @(posedge clk_i);
         t--;
         if (txd_i === 1'b0) begin
            repeat (div_v / 2) @(posedge clk_i);
            for (int k = 0; k < 8; k++) begin
               repeat (div_v) @(posedge clk_i);
               b[k] = txd_i;
            end
            if (par_v inside {PAR_EVEN, PAR_ODD}) begin
               repeat (div_v) @(posedge clk_i);
               if (txd_i !== par_of(b)) fmt_ok = 1'b0;
            end
            repeat (div_v) @(posedge clk_i);
            if (txd_i !== 1'b1 || de_i !== 1'b1) fmt_ok = 1'b0;
            if (rx_n < 40) begin
               rx_b[rx_n] = b;
               rx_n++;
            end
            t = 30 * div_v;
         end
      end
      repeat (20 * div_v) @(posedge clk_i);
   endtask
endmodule // mrs_master_model

`default_nettype wire

// *** dv/tb_mrs_modbus_slave.sv ***
/*
 * Bench for the modbus slave engine: apb register access and request
 * frames through the master model, checked against expected answers.
 * Assumes CLK_HZ_P = 100000, so 9600 baud is 10 cycles a bit.
 */
`timescale 1ns/1ps
`default_nettype none

module tb_mrs_modbus_slave;
   import mrs_pkg::*;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [31:0] prdata, rdata;
   logic pready, pslverr, rerr, rxd, txd, de;
   int fail_count = 0;
   int n_compared = 0;
   int answered = 0;
   int cyc = 0;
   always #5 clk = ~clk;
   mrs_modbus_slave #(.CLK_HZ_P(100000)) mrs_modbus_slave_i (
      .CLOCK_I(clk), .RESET_N_I(rst_n), .PSEL_I(psel), .PENABLE_I(penable),
      .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata),
      .PREADY_O(pready), .PSLVERR_O(pslverr), .RXD_I(rxd), .TXD_O(txd), .DE_O(de));
   mrs_master_model mrs_master_model_i (.clk_i(clk), .txd_i(txd), .de_i(de), .rxd_o(rxd));

   ////////////////////////////////////////
   task automatic end_sim();
      $display("compared %0d, mismatches %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         $display("FAIL %s expected %h seen %h", what, exp, seen);
         fail_count++;
      end
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1);
      rdata = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      // one wait state: ready seen at the second access edge
      chk("apb wait", 32'(n), 32'h0000_0002);
   endtask
   task automatic rd_chk(input string what, input logic [11:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0000_0000);
      chk(what, rdata, exp);
   endtask
   // bytes are right-aligned in q and e; m of 0 means no answer expected
   task automatic run(input int n, input logic [127:0] q, input int m, input logic [127:0] e);
      int k;
      for (int i = 0; i < n; i++) mrs_master_model_i.tx_b[i] = q[8*(n-1-i) +: 8];
      mrs_master_model_i.send(n);
      mrs_master_model_i.recv();
      k = mrs_master_model_i.rx_n;
      if (m > 0) answered++;
      chk("reply length", 32'(k), 32'(m == 0 ? 0 : m + 2));
      for (int i = 0; i < m && i < k; i++) chk("reply byte", mrs_master_model_i.rx_b[i],
         e[8*(m-1-i) +: 8]);
      if (m > 0 && k > 1) chk("reply crc", {mrs_master_model_i.rx_b[k-1],
         mrs_master_model_i.rx_b[k-2]}, mrs_master_model_i.crc_of(1'b1, k - 2));
      chk("char format", mrs_master_model_i.fmt_ok, 32'h0000_0001);
   endtask
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 90000) begin
         $display("FAIL run time expected done seen hang");
         fail_count++;
         end_sim();
      end
   end

   ////////////////////////////////////////
   initial begin
      repeat (12) @(posedge clk);
      rst_n <= 1'b1;
      repeat (400) @(posedge clk);
      rd_chk("ctrl reset", OFS_CTRL, CTRL_RESET);
      rd_chk("prot reset", OFS_PROT, PROT_RESET);
      apb(1'b0, 12'h0FC, 32'h0000_0000);
      chk("unmapped err", {31'h0, rerr}, 32'h0000_0001);
      apb(1'b1, OFS_MEM + 12'h008, 32'h0000_1111);
      apb(1'b1, OFS_MEM + 12'h00C, 32'h0000_012C);
      rd_chk("mem word 3", OFS_MEM + 12'h00C, 32'h0000_012C);
      $display("test registers done");
      run(6, 128'h0103_0002_0002, 7, 128'h0103_04_1111_012C);
      run(6, 128'h0103_0000_0011, 3, 128'h0183_03);
      run(6, 128'h0103_0000_0000, 3, 128'h0183_03);
      run(6, 128'h0103_001F_0002, 3, 128'h0183_02);
      $display("test read done");
      run(6, 128'h0141_0005_EC78, 6, 128'h0141_0005_EC78);
      rd_chk("mem word 5", OFS_MEM + 12'h014, 32'h0000_EC78);
      apb(1'b1, OFS_PROT, 32'h0000_0060);
      apb(1'b1, OFS_CTRL, CTRL_RESET | 32'h0000_4000);
      run(6, 128'h0141_0006_1234, 3, 128'h01C1_01);
      run(11, 128'h0142_0005_0002_04_AAAA_BBBB, 3, 128'h01C2_01);
      rd_chk("protected 5", OFS_MEM + 12'h014, 32'h0000_EC78);
      rd_chk("protected 6", OFS_MEM + 12'h018, 32'h0000_0000);
      apb(1'b1, OFS_CTRL, CTRL_RESET);
      run(6, 128'h0141_0006_1234, 6, 128'h0141_0006_1234);
      rd_chk("mem word 6", OFS_MEM + 12'h018, 32'h0000_1234);
      $display("test volatile write done");
      run(6, 128'h0106_0007_5A5A, 6, 128'h0106_0007_5A5A);
      run(11, 128'h0110_0008_0002_04_0102_0304, 6, 128'h0110_0008_0002);
      run(9, 128'h0142_000A_0001_02_BEEF, 6, 128'h0142_000A_0001);
      rd_chk("mem word 9", OFS_MEM + 12'h024, 32'h0000_0304);
      rd_chk("mem word 10", OFS_MEM + 12'h028, 32'h0000_BEEF);
      run(6, 128'h0108_0000_A537, 6, 128'h0108_0000_A537);
      run(6, 128'h0108_0001_A537, 3, 128'h0188_01);
      run(6, 128'h0107_0000_0000, 3, 128'h0187_01);
      $display("test functions done");
      mrs_master_model_i.bad_v = 1'b1;
      run(6, 128'h0103_0000_0001, 0, 128'h0);
      mrs_master_model_i.bad_v = 1'b0;
      apb(1'b0, OFS_STAT, 32'h0000_0000);
      chk("frame counts", rdata[15:0], {8'h01, 8'(answered)});
      run(6, 128'h0503_0000_0001, 0, 128'h0);
      run(6, 128'h0041_0009_7777, 0, 128'h0);
      rd_chk("broadcast write", OFS_MEM + 12'h024, 32'h0000_7777);
      $display("test silent frames done");
      apb(1'b1, OFS_CTRL, 32'h0000_29F7);
      mrs_master_model_i.par_v = PAR_EVEN;
      mrs_master_model_i.stop2_v = 1'b1;
      run(6, 128'hF708_0000_A537, 6, 128'hF708_0000_A537);
      run(6, 128'h0108_0000_A537, 0, 128'h0);
      apb(1'b1, OFS_CTRL, 32'h0000_12F7);
      mrs_master_model_i.div_v = 5;
      mrs_master_model_i.par_v = PAR_ODD;
      mrs_master_model_i.stop2_v = 1'b0;
      run(6, 128'hF708_0000_1E5C, 6, 128'hF708_0000_1E5C);
      $display("test formats done");
      end_sim();
   end
endmodule // tb_mrs_modbus_slave

`default_nettype wire
